// ### src/tcrp_edge_detect.sv
`timescale 1ns/10ps
// two-stage synchroniser plus edge detector for an external pin
module tcrp_edge_detect (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic meta;  // first stage, read only by sync
    logic sync;  // second stage
    logic prev;  // previous synchronised level

    // ------------------------------------------------------------
    // synchroniser and history
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    assign rise = sync && !prev;
    assign fall = !sync && prev;
endmodule

// ### src/tcrp_pkg.sv
package tcrp_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_COUNT_HI = 4'h0;   // count high byte
    localparam logic [3:0] OFF_COUNT_LO = 4'h1;   // count low byte
    localparam logic [3:0] OFF_RELOAD_HI = 4'h2;  // reload high byte
    localparam logic [3:0] OFF_RELOAD_LO = 4'h3;  // reload low byte
    localparam logic [3:0] OFF_DUTY_HI = 4'h4;    // duty/capture high byte
    localparam logic [3:0] OFF_DUTY_LO = 4'h5;    // duty/capture low byte
    localparam logic [3:0] OFF_CTL_ZERO = 4'h6;   // timer_control_zero
    localparam logic [3:0] OFF_CTL_ONE = 4'h7;    // timer_control_one
    localparam logic [3:0] OFF_CTL_TWO = 4'h8;    // timer_control_two
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h9; // sticky event status
    localparam logic [3:0] OFF_IRQ_MASK = 4'hA;   // event mask

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL0_MODE_HI = 7;      // high mode bit in control zero
    localparam int CTL0_CAPCAUSE = 0;     // capture_cause_flag
    localparam int CTL1_RUN = 7;          // timer_run_bit
    localparam int CTL1_POL = 6;          // input_edge_polarity
    localparam int CTL1_PRESCALE_EXPONENT_HI = 5;      // prescale_exponent msb
    localparam int CTL1_PRESCALE_EXPONENT_LO = 3;      // prescale_exponent lsb
    localparam int CTL2_DUTY_BUF = 5;     // duty_write_buffer_control
    localparam int CTL2_BOTH_EDGE = 4;    // both_edge_select
    localparam int CTL2_CLK_SRC = 0;      // clock_source_select
    localparam int STAT_CAPTURE = 0;      // capture event status bit
    localparam int STAT_RELOAD = 1;       // reload event status bit

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] CTL2_RESET = 8'h00;
    localparam logic [7:0] CTL2_WMASK = 8'h31;      // writable bits of control two
    localparam logic [15:0] COUNT_RESTART = 16'h0001;
    localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
    localparam logic [7:0] PRESCALE_MAX = 8'h7F;    // 2^7 - 1

    // ------------------------------------------------------------
    // operating modes, 4-bit codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TCRP_ONE_SHOT = 4'h0,
        TCRP_CONTINUOUS = 4'h1,
        TCRP_EVENT_COUNT = 4'h2,
        TCRP_PWM_SINGLE = 4'h3,
        TCRP_CAPTURE = 4'h4,
        TCRP_COMPARE = 4'h5,
        TCRP_GATED = 4'h6,
        TCRP_CAP_CMP = 4'h7,
        TCRP_PWM_DUAL = 4'h8,
        TCRP_CAP_RESTART = 4'h9,
        TCRP_CMP_COUNT = 4'hA,
        TCRP_TRIG_ONE_SHOT = 4'hB,
        TCRP_DEMOD = 4'hC
    } tcrp_mode_t;

    // run state, one-hot
    typedef enum logic [1:0] {
        TCRP_IDLE = 2'b01,
        TCRP_RUN = 2'b10
    } tcrp_state_t;

endpackage

// ### src/tcrp_prescaler.sv
`timescale 1ns/10ps
// power-of-two divider producing one tick pulse per division period
module tcrp_prescaler (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic enable,
    input wire logic [2:0] exponent,
    output logic tick
);
    logic [7:0] div_count; // free divider count
    logic [7:0] limit;     // terminal value for the exponent

    assign limit = 8'((9'h001 << exponent) - 9'h001);

    // ------------------------------------------------------------
    // divider, held in initial state while disabled
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_count <= 8'h00;
        end else if (!enable) begin
            div_count <= 8'h00; // realign on every restart [R8]
        end else if (div_count >= limit) begin
            div_count <= 8'h00;
        end else begin
            div_count <= div_count + 8'h01;
        end
    end

    // tick when the period closes, divide by 2^exponent [R7]
    assign tick = enable && (div_count >= limit);
endmodule

// ### src/tcrp_timer.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
// Overview of operation
// [R1] capture edge copies count into duty registers
// [R2] polarity bit picks rising or falling edge
// [R3] capture interrupts, restarts count at 0001H
// [R4] capture sets capture-cause flag
// [R5] count to reload, interrupt, restart 0001H
// [R6] reload clears capture-cause flag
// [R7] prescaler divides by two to exponent
// [R8] prescaler reset while timer disabled
// [R9] mode is high bit plus three bits
// [R10] low mode codes decode one-shot through capture-compare
// [R11] high mode codes decode dual pwm through demodulation
// [R12] code 0011 is single-output pwm
// [R13] control two: clock source, both-edge select, duty buffer control, resets zero
// [R14] duty writes buffered while running, update bit 0
// [R15] demodulation both-edge bit uses any edge
module tcrp_timer (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic TIMER_IN,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic IRQ,
    output logic [3:0] MODE,
    output logic CLOCK_SOURCE
);
    // ------------------------------------------------------------
    // registers and internal signals
    // ------------------------------------------------------------
    logic [15:0] count;          // running count
    logic [15:0] reload;         // reload value
    logic [15:0] duty;           // duty / capture value
    logic [15:0] duty_pending;   // buffered duty write
    logic [1:0] duty_pend_flag;  // pending bytes: [1] high, [0] low
    logic [7:0] ctl_zero;        // timer_control_zero
    logic [7:0] ctl_one;         // timer_control_one
    logic [7:0] ctl_two;         // timer_control_two
    logic [1:0] irq_status;      // sticky events
    logic [1:0] irq_mask;        // event mask
    tcrp_pkg::tcrp_state_t state;        // run state
    tcrp_pkg::tcrp_mode_t timer_mode_select; // decoded mode
    logic run_bit;               // timer_run_bit
    logic tick;                  // prescaled clock tick
    logic in_rise;               // synchronised rising edge
    logic in_fall;               // synchronised falling edge
    logic capture_edge;          // selected capture edge
    logic capture_event;         // capture in capture-restart or demodulation mode
    logic reload_event;          // count reached reload
    logic restart_event;         // any restart to 0001H
    logic buffer_duty;           // duty writes are buffered
    logic wr_duty_hi;            // write to duty high
    logic wr_duty_lo;            // write to duty low
    logic [1:0] next_status;     // status after events and read clear
    logic mode_is_capture;       // any mode that captures on edges

    assign run_bit = ctl_one[tcrp_pkg::CTL1_RUN];

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // four-bit mode from control zero high bit and control one low bits
    always_comb begin
        case ({ctl_zero[tcrp_pkg::CTL0_MODE_HI], ctl_one[2:0]}) // [R9]
            4'h0: timer_mode_select = tcrp_pkg::TCRP_ONE_SHOT;       // [R10]
            4'h1: timer_mode_select = tcrp_pkg::TCRP_CONTINUOUS;     // [R10]
            4'h2: timer_mode_select = tcrp_pkg::TCRP_EVENT_COUNT;    // [R10]
            4'h3: timer_mode_select = tcrp_pkg::TCRP_PWM_SINGLE;     // [R12]
            4'h4: timer_mode_select = tcrp_pkg::TCRP_CAPTURE;        // [R10]
            4'h5: timer_mode_select = tcrp_pkg::TCRP_COMPARE;        // [R10]
            4'h6: timer_mode_select = tcrp_pkg::TCRP_GATED;          // [R10]
            4'h7: timer_mode_select = tcrp_pkg::TCRP_CAP_CMP;        // [R10]
            4'h8: timer_mode_select = tcrp_pkg::TCRP_PWM_DUAL;       // [R11]
            4'h9: timer_mode_select = tcrp_pkg::TCRP_CAP_RESTART;    // [R11]
            4'hA: timer_mode_select = tcrp_pkg::TCRP_CMP_COUNT;      // [R11]
            4'hB: timer_mode_select = tcrp_pkg::TCRP_TRIG_ONE_SHOT;  // [R11]
            4'hC: timer_mode_select = tcrp_pkg::TCRP_DEMOD;          // [R11]
            default: timer_mode_select = tcrp_pkg::TCRP_ONE_SHOT;    // unused codes
        endcase
    end

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    tcrp_prescaler u_prescaler (
        .SYS_CLK(SYS_CLK),
        .RESET_N(RESET_N),
        .enable(run_bit),
        .exponent(ctl_one[tcrp_pkg::CTL1_PRESCALE_EXPONENT_HI:tcrp_pkg::CTL1_PRESCALE_EXPONENT_LO]),
        .tick(tick)
    );

    tcrp_edge_detect u_edge (
        .SYS_CLK(SYS_CLK),
        .RESET_N(RESET_N),
        .pin(TIMER_IN),
        .rise(in_rise),
        .fall(in_fall)
    );

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    // edge choice: polarity bit, or both edges in demodulation with both-edge select set
    always_comb begin
        if (timer_mode_select == tcrp_pkg::TCRP_DEMOD && ctl_two[tcrp_pkg::CTL2_BOTH_EDGE]) begin
            capture_edge = in_rise || in_fall; // [R15]
        end else if (ctl_one[tcrp_pkg::CTL1_POL]) begin
            capture_edge = in_fall; // [R2]
        end else begin
            capture_edge = in_rise; // [R2]
        end
    end

    assign mode_is_capture = (timer_mode_select == tcrp_pkg::TCRP_CAP_RESTART) ||
                             (timer_mode_select == tcrp_pkg::TCRP_DEMOD);
    assign capture_event = (state == tcrp_pkg::TCRP_RUN) && mode_is_capture && capture_edge;
    assign reload_event = (state == tcrp_pkg::TCRP_RUN) && tick && !capture_event && (count >= reload);
    assign restart_event = capture_event || reload_event;
    assign buffer_duty = run_bit && !ctl_two[tcrp_pkg::CTL2_DUTY_BUF];
    assign wr_duty_hi = WR && (ADDR == tcrp_pkg::OFF_DUTY_HI);
    assign wr_duty_lo = WR && (ADDR == tcrp_pkg::OFF_DUTY_LO);

    // ------------------------------------------------------------
    // run state
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= tcrp_pkg::TCRP_IDLE;
        end else begin
            case (state)
                tcrp_pkg::TCRP_IDLE: begin
                    if (run_bit) begin
                        state <= tcrp_pkg::TCRP_RUN;
                    end
                end
                tcrp_pkg::TCRP_RUN: begin
                    if (!run_bit) begin
                        state <= tcrp_pkg::TCRP_IDLE;
                    end
                end
                default: state <= tcrp_pkg::TCRP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            count <= tcrp_pkg::COUNT_RESTART;
        end else if (WR && ADDR == tcrp_pkg::OFF_COUNT_HI) begin
            count[15:8] <= WDATA;
        end else if (WR && ADDR == tcrp_pkg::OFF_COUNT_LO) begin
            count[7:0] <= WDATA;
        end else if (restart_event) begin
            count <= tcrp_pkg::COUNT_RESTART; // [R3] [R5]
        end else if (state == tcrp_pkg::TCRP_RUN && tick) begin
            count <= count + 16'h0001; // keep counting
        end
    end

    // ------------------------------------------------------------
    // reload register
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            reload <= tcrp_pkg::RELOAD_RESET;
        end else if (WR && ADDR == tcrp_pkg::OFF_RELOAD_HI) begin
            reload[15:8] <= WDATA;
        end else if (WR && ADDR == tcrp_pkg::OFF_RELOAD_LO) begin
            reload[7:0] <= WDATA;
        end
    end

    // ------------------------------------------------------------
    // duty / capture register with write buffer
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            duty <= 16'h0000;
        end else if (capture_event) begin
            duty <= count; // [R1]
        end else begin
            if (wr_duty_hi && !buffer_duty) begin
                duty[15:8] <= WDATA; // direct write [R14]
            end else if (reload_event && duty_pend_flag[1]) begin
                duty[15:8] <= duty_pending[15:8]; // apply at reload [R14]
            end
            if (wr_duty_lo && !buffer_duty) begin
                duty[7:0] <= WDATA; // direct write [R14]
            end else if (reload_event && duty_pend_flag[0]) begin
                duty[7:0] <= duty_pending[7:0]; // apply at reload [R14]
            end
        end
    end

    // pending buffer, filled while running with update bit low
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            duty_pending <= 16'h0000;
            duty_pend_flag <= 2'b00;
        end else begin
            if (wr_duty_hi && buffer_duty) begin
                duty_pending[15:8] <= WDATA; // [R14]
                duty_pend_flag[1] <= 1'b1;
            end else if (restart_event || wr_duty_hi) begin
                duty_pend_flag[1] <= 1'b0;
            end
            if (wr_duty_lo && buffer_duty) begin
                duty_pending[7:0] <= WDATA; // [R14]
                duty_pend_flag[0] <= 1'b1;
            end else if (restart_event || wr_duty_lo) begin
                duty_pend_flag[0] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // control zero: mode high bit writable, cause flag set by hardware
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl_zero <= 8'h00;
        end else begin
            if (WR && ADDR == tcrp_pkg::OFF_CTL_ZERO) begin
                ctl_zero[7:1] <= WDATA[7:1];
            end
            if (capture_event) begin
                ctl_zero[tcrp_pkg::CTL0_CAPCAUSE] <= 1'b1; // [R4]
            end else if (reload_event) begin
                ctl_zero[tcrp_pkg::CTL0_CAPCAUSE] <= 1'b0; // [R6]
            end
        end
    end

    // control one: run, polarity, prescale, low mode bits
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl_one <= 8'h00;
        end else if (WR && ADDR == tcrp_pkg::OFF_CTL_ONE) begin
            ctl_one <= WDATA;
        end
    end

    // control two: reserved bits held at zero
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl_two <= tcrp_pkg::CTL2_RESET; // [R13]
        end else if (WR && ADDR == tcrp_pkg::OFF_CTL_TWO) begin
            ctl_two <= WDATA & tcrp_pkg::CTL2_WMASK; // [R13]
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    // read clears, a same-cycle event wins
    always_comb begin
        next_status = irq_status;
        if (RD && ADDR == tcrp_pkg::OFF_IRQ_STATUS) begin
            next_status = 2'b00;
        end
        if (capture_event) begin
            next_status[tcrp_pkg::STAT_CAPTURE] = 1'b1; // [R3]
        end
        if (reload_event) begin
            next_status[tcrp_pkg::STAT_RELOAD] = 1'b1; // [R5]
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_status <= 2'b00;
        end else begin
            irq_status <= next_status;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_mask <= 2'b00;
        end else if (WR && ADDR == tcrp_pkg::OFF_IRQ_MASK) begin
            irq_mask <= WDATA[1:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(next_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // read port and status outputs
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                tcrp_pkg::OFF_COUNT_HI: RDATA <= count[15:8];
                tcrp_pkg::OFF_COUNT_LO: RDATA <= count[7:0];
                tcrp_pkg::OFF_RELOAD_HI: RDATA <= reload[15:8];
                tcrp_pkg::OFF_RELOAD_LO: RDATA <= reload[7:0];
                tcrp_pkg::OFF_DUTY_HI: RDATA <= duty[15:8];
                tcrp_pkg::OFF_DUTY_LO: RDATA <= duty[7:0];
                tcrp_pkg::OFF_CTL_ZERO: RDATA <= ctl_zero;
                tcrp_pkg::OFF_CTL_ONE: RDATA <= ctl_one;
                tcrp_pkg::OFF_CTL_TWO: RDATA <= ctl_two;
                tcrp_pkg::OFF_IRQ_STATUS: RDATA <= {6'h00, irq_status};
                tcrp_pkg::OFF_IRQ_MASK: RDATA <= {6'h00, irq_mask};
                default: RDATA <= 8'h00; // unmapped
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            MODE <= 4'h0;
            CLOCK_SOURCE <= 1'b0;
        end else begin
            MODE <= timer_mode_select;
            CLOCK_SOURCE <= ctl_two[tcrp_pkg::CTL2_CLK_SRC]; // [R13]
        end
    end
endmodule

// ### verification/tb_timer_capture_restart_prescale.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// self-checking timer bench
// ------------------------------------------------------------
module tb_timer_capture_restart_prescale;
    logic SYS_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic TIMER_IN; // from source model
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0, RD = 1'b0;
    logic [7:0] RDATA;
    logic IRQ, CLOCK_SOURCE;
    logic [3:0] MODE;
    int err_count = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h0000_B608; // fixed start value
    always #20 SYS_CLK = ~SYS_CLK;
    tcrp_timer uut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .TIMER_IN(TIMER_IN), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .MODE(MODE), .CLOCK_SOURCE(CLOCK_SOURCE));
    tcrp_input_model src (.SYS_CLK(SYS_CLK), .pin(TIMER_IN));
    // xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // unused codes show zero
    function automatic logic [3:0] mode_of(input logic [3:0] c);
        return (c > 4'hC) ? 4'h0 : c;
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge SYS_CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        @(negedge SYS_CLK);
        d = RDATA;
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #(40 * 20000);
        err_count++;
        wrap_up();
    end
    initial begin
        logic [7:0] d, h;
        logic [15:0] v;
        int m, r;
        repeat (8) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        rd(tcrp_pkg::OFF_CTL_TWO, d);
        chk("ctl_two reset", 16'h0000, 16'(d));
        rd(tcrp_pkg::OFF_RELOAD_HI, d);
        chk("reload hi reset", 16'h00FF, 16'(d));
        rd(4'hF, d);
        chk("unmapped read", 16'h0000, 16'(d));
        $display("test reset done");
        // every mode code
        for (int i = 0; i < 16; i++) begin
            wr(tcrp_pkg::OFF_CTL_ZERO, {i[3], 7'h00});
            wr(tcrp_pkg::OFF_CTL_ONE, {5'h00, i[2:0]});
            repeat (2) @(negedge SYS_CLK);
            chk("mode", 16'(mode_of(4'(i))), 16'(MODE));
        end
        $display("test mode done");
        for (int i = 0; i < 8; i++) begin
            h = 8'(rnd());
            wr(tcrp_pkg::OFF_CTL_TWO, h);
            rd(tcrp_pkg::OFF_CTL_TWO, d);
            chk("ctl_two", 16'(h & tcrp_pkg::CTL2_WMASK), 16'(d));
            chk("clock source", 16'(h[0]), 16'(CLOCK_SOURCE));
        end
        $display("test ctl two done");
        // rising-edge capture for prescale exponents 0 to 3
        wr(tcrp_pkg::OFF_IRQ_MASK, 8'h03);
        wr(tcrp_pkg::OFF_CTL_ZERO, 8'h80);
        for (int p = 0; p < 4; p++) begin
            m = 64 + int'(rnd() % 32'd64);
            wr(tcrp_pkg::OFF_COUNT_HI, 8'h00);
            wr(tcrp_pkg::OFF_COUNT_LO, 8'h01);
            wr(tcrp_pkg::OFF_CTL_ONE, {2'b10, 3'(p), 3'b001});
            repeat (m) @(posedge SYS_CLK);
            src.level(1'b1, 8);
            @(negedge SYS_CLK);
            chk("capture irq", 16'h0001, 16'(IRQ));
            rd(tcrp_pkg::OFF_IRQ_STATUS, d);
            chk("status capture", 16'h0001, 16'(d));
            rd(tcrp_pkg::OFF_CTL_ZERO, d);
            chk("cause flag set", 16'h0081, 16'(d));
            rd(tcrp_pkg::OFF_DUTY_HI, v[15:8]);
            rd(tcrp_pkg::OFF_DUTY_LO, v[7:0]);
            chk("capture value", 16'h0001, 16'(v >= 16'(m >> p) && v <= 16'(((m + 8) >> p) + 2)));
            rd(tcrp_pkg::OFF_COUNT_LO, d);
            chk("count restarted", 16'h0001, 16'(16'(d) < v));
            wr(tcrp_pkg::OFF_CTL_ONE, 8'h01); // stop clears the divider
            src.level(1'b0, 8);
            chk("irq cleared", 16'h0000, 16'(IRQ));
        end
        $display("test capture done");
        // falling polarity
        wr(tcrp_pkg::OFF_CTL_ONE, 8'hC1);
        src.level(1'b1, 8);
        rd(tcrp_pkg::OFF_IRQ_STATUS, d);
        chk("rise ignored", 16'h0000, 16'(d));
        src.level(1'b0, 8);
        rd(tcrp_pkg::OFF_IRQ_STATUS, d);
        chk("fall captured", 16'h0001, 16'(d));
        $display("test polarity done");
        // reload with no capture
        wr(tcrp_pkg::OFF_CTL_ONE, 8'h01);
        r = 4 + int'(rnd() % 32'd8);
        wr(tcrp_pkg::OFF_RELOAD_HI, 8'h00);
        wr(tcrp_pkg::OFF_RELOAD_LO, 8'(r));
        wr(tcrp_pkg::OFF_COUNT_LO, 8'h01);
        wr(tcrp_pkg::OFF_CTL_ONE, 8'h81);
        repeat (r + 6) @(posedge SYS_CLK);
        rd(tcrp_pkg::OFF_IRQ_STATUS, d);
        chk("status reload", 16'h0001, 16'(d[1]));
        rd(tcrp_pkg::OFF_CTL_ZERO, d);
        chk("cause flag clear", 16'h0080, 16'(d));
        rd(tcrp_pkg::OFF_COUNT_LO, d);
        chk("count in range", 16'h0001, 16'(d <= 8'(r) && d != 8'h00));
        wr(tcrp_pkg::OFF_IRQ_MASK, 8'h00);
        repeat (3 * r) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        chk("irq masked", 16'h0000, 16'(IRQ));
        $display("test reload done");
        wrap_up();
    end
endmodule
bind tcrp_timer tcrp_timer_sva chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .TIMER_IN(TIMER_IN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .MODE(MODE), .CLOCK_SOURCE(CLOCK_SOURCE));

// ### verification/tcrp_input_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// source for the timer input pin
// ------------------------------------------------------------
module tcrp_input_model (
    input wire logic SYS_CLK,
    output logic pin
);
    initial pin = 1'b0;
    // move pin after an edge, hold it
    task automatic level(input logic v, input int hold);
        @(posedge SYS_CLK);
        pin <= v;
        repeat (hold) @(posedge SYS_CLK);
    endtask
endmodule

// ### verification/tcrp_timer_sva.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module tcrp_timer_sva (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic TIMER_IN,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic IRQ,
    input wire logic [3:0] MODE,
    input wire logic CLOCK_SOURCE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    logic [7:0] ctl0; // shadow of control zero
    logic [7:0] ctl1; // shadow of control one
    logic [1:0] mask; // shadow of event mask
    logic [3:0] exp_mode; // expected mode
    // shadow software writes
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl0 <= 8'h00;
            ctl1 <= 8'h00;
            mask <= 2'b00;
        end else if (WR) begin
            if (ADDR == tcrp_pkg::OFF_CTL_ZERO) ctl0 <= WDATA;
            if (ADDR == tcrp_pkg::OFF_CTL_ONE) ctl1 <= WDATA;
            if (ADDR == tcrp_pkg::OFF_IRQ_MASK) mask <= WDATA[1:0];
        end
    end
    // unused codes show zero
    assign exp_mode = ({ctl0[7], ctl1[2:0]} > 4'hC) ? 4'h0 : {ctl0[7], ctl1[2:0]};
    a_rdata_idle_zero: assert property (!RD |=> RDATA == 8'h00) else $error("idle read data");
    a_unmapped_read_zero: assert property (RD && ADDR > tcrp_pkg::OFF_IRQ_MASK |=> RDATA == 8'h00)
        else $error("unmapped read");
    a_ctl2_reserved_zero: assert property (RD && ADDR == tcrp_pkg::OFF_CTL_TWO |=>
        (RDATA[7:6] == 2'b00) && (RDATA[3:1] == 3'b000)) else $error("reserved bits");
    a_clk_src_follow: assert property (WR && ADDR == tcrp_pkg::OFF_CTL_TWO |=> ##1
        CLOCK_SOURCE == $past(WDATA[0], 2)) else $error("clock source");
    a_mode_code_follow: assert property ($changed(exp_mode) |-> ##[0:1] MODE == exp_mode)
        else $error("mode code");
    a_capture_raises_irq: assert property ($rose(TIMER_IN) && exp_mode == 4'h9 && ctl1[7] && !ctl1[6]
        && mask[0] |-> ##[3:6] IRQ) else $error("capture irq");
    a_irq_masked_low: assert property (mask == 2'b00 && $past(mask) == 2'b00 |-> !IRQ)
        else $error("masked irq");
    a_ctl2_readback: assert property (WR && ADDR == tcrp_pkg::OFF_CTL_TWO ##2 RD && ADDR == tcrp_pkg::OFF_CTL_TWO
        |=> RDATA == ($past(WDATA, 3) & tcrp_pkg::CTL2_WMASK)) else $error("ctl two readback");
    c_capture_mode: cover property (MODE == 4'h9 && $rose(IRQ));
    c_status_reload: cover property (RD && ADDR == tcrp_pkg::OFF_IRQ_STATUS ##1 RDATA[1]);
    c_status_capture: cover property (RD && ADDR == tcrp_pkg::OFF_IRQ_STATUS ##1 RDATA[0]);
endmodule
